// ==== csd_pkg.sv ====
// Purpose: shared constants for the core memory strap decoder
// Assumes: one 40 MHz clock, avalon-mm slave with 32-bit data
// Notes: a block is 16K double words of 36 bits
package csd_pkg;
  // ==========================================================
  // geometry
  localparam int unsigned CSD_START_W = 9;
  localparam int unsigned CSD_STACKS = 4;
  localparam int unsigned CSD_BLOCK_DW_BITS = 14;
  localparam int unsigned CSD_CAP_W = 4;
  localparam int unsigned CSD_DW_ADDR_W = CSD_START_W + CSD_BLOCK_DW_BITS + 1;
  localparam int unsigned CSD_BLK_W = CSD_START_W + 1;
  localparam logic [CSD_CAP_W-1:0] CSD_BLOCKS_16K = 4'h1;
  localparam logic [CSD_CAP_W-1:0] CSD_BLOCKS_32K = 4'h2;
  // ==========================================================
  // register bus
  localparam int unsigned CSD_BUS_AW = 4;
  localparam logic [CSD_BUS_AW-1:0] CSD_OFS_CONFIG = 4'h0;
  localparam logic [CSD_BUS_AW-1:0] CSD_OFS_EVENT = 4'h4;
  localparam logic [CSD_BUS_AW-1:0] CSD_OFS_MASK = 4'h8;
  localparam logic [CSD_BUS_AW-1:0] CSD_OFS_CONTROL = 4'hC;
  // config register fields
  localparam int unsigned CSD_CFG_START_LSB = 0;
  localparam int unsigned CSD_CFG_IL_BIT = 9;
  localparam int unsigned CSD_CFG_EVEN_BIT = 10;
  localparam int unsigned CSD_CFG_ERR_BIT = 11;
  localparam int unsigned CSD_CFG_CAP_LSB = 12;
  localparam int unsigned CSD_CFG_SIZE_LSB = 16;
  localparam int unsigned CSD_CFG_PRES_LSB = 20;
  // event, mask and control fields
  localparam int unsigned CSD_EV_W = 3;
  localparam int unsigned CSD_EV_ERR_BIT = 0;
  localparam int unsigned CSD_EV_REFUSE_BIT = 1;
  localparam int unsigned CSD_EV_HIT_BIT = 2;
  localparam int unsigned CSD_CTL_ENABLE_BIT = 0;
  localparam logic [CSD_EV_W-1:0] CSD_MASK_RESET = 3'h0;
  localparam logic CSD_CTL_ENABLE_RESET = 1'b1;
endpackage

// ==== csd_strap_decode.sv ====
// Summary of operation
// - start address counts 16K double-word blocks below
// - nine straps form the 9-bit start block
// - closed strap reads 0, open reads 1
// - first strap is lsb, ninth is msb
// - open interleave strap enables interleaved operation
// - interleaved, open even/odd strap answers even
// - interleaved, closed even/odd strap answers odd
// - interleave closed ignores even/odd strap
// - accept 16K and 32K stacks per position
// - order error lights indicator, refuses all access
//
// Purpose: strap decode and address match of a core memory controller
// Assumes: straps and bus request synchronous to sys_clk
// Notes: straps are resampled every cycle so a corrected setup recovers
`timescale 1ns/10ps
module csd_strap_decode
  import csd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CSD_START_W-1:0] start_addr_strap,
  input wire logic interleave_enable_strap,
  input wire logic even_odd_select_strap,
  input wire logic [CSD_STACKS-1:0] stack_present,
  input wire logic [CSD_STACKS-1:0] stack_is_32k,
  input wire logic mem_req_valid,
  input wire logic [CSD_DW_ADDR_W-1:0] mem_req_dw_addr,
  output logic mem_hit,
  output logic mem_refuse,
  output logic config_error_indicator,
  input wire logic [CSD_BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  // ==========================================================
  // strap sampling
  logic [CSD_START_W-1:0] start_q;
  logic il_q;
  logic even_q;
  logic [CSD_STACKS-1:0] pres_q;
  logic [CSD_STACKS-1:0] big_q;

  // pin level is taken as is: closed pulls to 0, open floats to 1
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_q <= '0;
      il_q <= 1'b0;
      even_q <= 1'b0;
      pres_q <= '0;
      big_q <= '0;
    end else begin
      start_q <= start_addr_strap;
      il_q <= interleave_enable_strap;
      even_q <= even_odd_select_strap;
      pres_q <= stack_present;
      big_q <= stack_is_32k;
    end
  end

  // ==========================================================
  // capacity and stack order check
  logic [CSD_CAP_W-1:0] cap_blocks;
  logic order_err;

  always_comb begin
    cap_blocks = '0;
    order_err = 1'b0;
    for (int i = 0; i < CSD_STACKS; i++) begin
      if (pres_q[i]) begin
        cap_blocks = cap_blocks + (big_q[i] ? CSD_BLOCKS_32K : CSD_BLOCKS_16K);
      end
      for (int j = i + 1; j < CSD_STACKS; j++) begin
        if (pres_q[i] && big_q[i] && pres_q[j] && !big_q[j]) begin
          order_err = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // address match
  logic ctl_enable_q;
  logic [CSD_BLK_W-1:0] req_blk;
  logic [CSD_BLK_W-1:0] lo_blk;
  logic [CSD_BLK_W-1:0] hi_blk;
  logic half_ok;
  logic in_range;

  // the start straps count blocks held below this controller
  assign lo_blk = {1'b0, start_q};
  assign hi_blk = lo_blk + CSD_BLK_W'(cap_blocks);

  // interleaved pair shares one start; each half holds every other double word,
  // so the pair spans twice one frame and the low bit steers the half
  always_comb begin
    if (il_q) begin
      req_blk = CSD_BLK_W'(mem_req_dw_addr[CSD_DW_ADDR_W-1:CSD_BLOCK_DW_BITS+1]);
      half_ok = (mem_req_dw_addr[0] == 1'b0) ? even_q : !even_q;
    end else begin
      req_blk = CSD_BLK_W'(mem_req_dw_addr[CSD_DW_ADDR_W-1:CSD_BLOCK_DW_BITS]);
      half_ok = 1'b1;
    end
  end

  assign in_range = (req_blk >= lo_blk) && (req_blk < hi_blk);

  logic hit_q;
  logic refuse_q;
  logic err_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      hit_q <= mem_req_valid && ctl_enable_q && !order_err && in_range && half_ok;
      refuse_q <= mem_req_valid && order_err;
    end
  end

  // indicator follows the live configuration, so it clears once fixed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else begin
      err_q <= order_err;
    end
  end

  assign mem_hit = hit_q;
  assign mem_refuse = refuse_q;
  assign config_error_indicator = err_q;

  // ==========================================================
  // event flags and interrupt
  logic [CSD_EV_W-1:0] ev_q;
  logic [CSD_EV_W-1:0] mask_q;
  logic [CSD_EV_W-1:0] ev_set;
  logic irq_q;
  logic err_prev_q;
  logic ev_clear;
  logic bus_take;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_prev_q <= 1'b0;
    end else begin
      err_prev_q <= err_q;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[CSD_EV_ERR_BIT] = err_q && !err_prev_q;
    ev_set[CSD_EV_REFUSE_BIT] = refuse_q;
    ev_set[CSD_EV_HIT_BIT] = hit_q;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_clear ? '0 : ev_q) | ev_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((ev_clear ? '0 : ev_q) | ev_set) & mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // avalon slave: every access answers after exactly one wait cycle
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] cfg_word;

  assign bus_take = (avs_read || avs_write) && wait_q;
  assign ev_clear = bus_take && avs_read && (avs_address == CSD_OFS_EVENT);

  always_comb begin
    cfg_word = '0;
    cfg_word[CSD_CFG_START_LSB +: CSD_START_W] = start_q;
    cfg_word[CSD_CFG_IL_BIT] = il_q;
    cfg_word[CSD_CFG_EVEN_BIT] = even_q;
    cfg_word[CSD_CFG_ERR_BIT] = err_q;
    cfg_word[CSD_CFG_CAP_LSB +: CSD_CAP_W] = cap_blocks;
    cfg_word[CSD_CFG_SIZE_LSB +: CSD_STACKS] = big_q;
    cfg_word[CSD_CFG_PRES_LSB +: CSD_STACKS] = pres_q;
  end

  always_comb begin
    rdata_d = '0;
    unique case (avs_address)
      CSD_OFS_CONFIG: rdata_d = cfg_word;
      CSD_OFS_EVENT: rdata_d[CSD_EV_W-1:0] = ev_q;
      CSD_OFS_MASK: rdata_d[CSD_EV_W-1:0] = mask_q;
      CSD_OFS_CONTROL: rdata_d[CSD_CTL_ENABLE_BIT] = ctl_enable_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !bus_take;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (bus_take) begin
      rdata_q <= avs_read ? rdata_d : '0;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // writes land on the take edge; only the low byte lane holds bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= CSD_MASK_RESET;
      ctl_enable_q <= CSD_CTL_ENABLE_RESET;
    end else if (bus_take && avs_write && avs_byteenable[0]) begin
      if (avs_address == CSD_OFS_MASK) begin
        mask_q <= avs_writedata[CSD_EV_W-1:0];
      end
      if (avs_address == CSD_OFS_CONTROL) begin
        ctl_enable_q <= avs_writedata[CSD_CTL_ENABLE_BIT];
      end
    end
  end
endmodule

// ==== csd_cache_model.sv ====
// Purpose: stand-in for the single bus master (cache)
// Assumes: bench calls send or idle right after a rising edge
// Notes: idle address is inverted so a stale address never looks valid
`timescale 1ns/10ps
module csd_cache_model
  import csd_pkg::*;
(
  input wire logic sys_clk,
  output logic mem_req_valid,
  output logic [CSD_DW_ADDR_W-1:0] mem_req_dw_addr
);
  initial begin
    mem_req_valid = 1'b0;
    mem_req_dw_addr = '0;
  end
  task automatic send(input logic [CSD_DW_ADDR_W-1:0] a);
    mem_req_valid <= 1'b1;
    mem_req_dw_addr <= a;
    @(posedge sys_clk);
  endtask
  task automatic idle;
    mem_req_valid <= 1'b0;
    mem_req_dw_addr <= ~mem_req_dw_addr;
    @(posedge sys_clk);
  endtask
endmodule

// ==== csd_strap_decode_properties.sv ====
// Purpose: port relations of the strap decoder
// Assumes: straps held still around requests
// Notes: stability guards hide the one-edge strap sampling delay
`timescale 1ns/10ps
module csd_props
  import csd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CSD_START_W-1:0] start_addr_strap,
  input wire logic interleave_enable_strap,
  input wire logic even_odd_select_strap,
  input wire logic mem_req_valid,
  input wire logic [CSD_DW_ADDR_W-1:0] mem_req_dw_addr,
  input wire logic mem_hit,
  input wire logic mem_refuse,
  input wire logic config_error_indicator,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  property p_no_both; mem_refuse |-> !mem_hit; endproperty
  a_no_both: assert property (p_no_both) else $error("hit with refuse");
  property p_hit_cause; mem_hit |-> $past(mem_req_valid); endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("hit without request");
  property p_ref_cause; mem_refuse |-> $past(mem_req_valid); endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("refuse without request");
  property p_refuse;
    mem_req_valid && config_error_indicator && $past(config_error_indicator) |=> mem_refuse;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access not refused");
  property p_half;
    mem_req_valid && interleave_enable_strap && $stable(even_odd_select_strap) &&
      (mem_req_dw_addr[0] == even_odd_select_strap) |=> !mem_hit;
  endproperty
  a_half: assert property (p_half) else $error("wrong half answered");
  property p_below;
    mem_req_valid && !interleave_enable_strap && $stable(start_addr_strap) &&
      mem_req_dw_addr[23:14] < {1'b0, start_addr_strap} |=> !mem_hit;
  endproperty
  a_below: assert property (p_below) else $error("hit below start");
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  c_hit: cover property (mem_hit);
  c_ref: cover property (mem_refuse);
  c_irq: cover property (irq);
endmodule

// ==== csd_strap_decode_tb_top.sv ====
// Purpose: random strap setups against decode, events and irq
// Assumes: byteenable tied to all lanes
// Notes: straps change only with the bus master idle
`timescale 1ns/10ps
module csd_strap_decode_tb_top;
  import csd_pkg::*;
  logic sys_clk = 0, rst = 1, il = 0, eo = 0, avs_read = 0, avs_write = 0, pend = 0, pe = 0;
  logic [8:0] st = '0;
  logic [3:0] pres = '0, big = '0, avs_address = '0;
  logic [31:0] avs_writedata = '0, seed, cfg, r, avs_readdata;
  logic mem_req_valid, mem_hit, mem_refuse, config_error_indicator, avs_waitrequest, irq;
  logic [23:0] mem_req_dw_addr;
  logic [1:0] mq[$];
  logic [31:0] rq[$];
  int checks = 0, mismatches = 0;
  always #12.5 sys_clk = ~sys_clk;
  csd_cache_model u_csd_cache_model (.sys_clk(sys_clk), .mem_req_valid(mem_req_valid),
    .mem_req_dw_addr(mem_req_dw_addr));
  csd_strap_decode u_csd_strap_decode (.sys_clk(sys_clk), .rst(rst), .start_addr_strap(st),
    .interleave_enable_strap(il), .even_odd_select_strap(eo), .stack_present(pres),
    .stack_is_32k(big), .mem_req_valid(mem_req_valid), .mem_req_dw_addr(mem_req_dw_addr),
    .mem_hit(mem_hit), .mem_refuse(mem_refuse), .config_error_indicator(config_error_indicator),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bus cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++t < 100);
    if (t >= 100) mismatches++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic int cap_of();
    cap_of = 0;
    for (int i = 0; i < 4; i++) if (pres[i]) cap_of += big[i] ? 2 : 1;
  endfunction
  function automatic logic err_of();
    err_of = 0;
    for (int i = 0; i < 4; i++)
      for (int j = i + 1; j < 4; j++) if (pres[i] && pres[j] && big[i] && !big[j]) err_of = 1;
  endfunction
  function automatic logic [1:0] exp_of(input logic [23:0] a);
    logic [9:0] b;
    b = il ? {1'b0, a[23:15]} : a[23:14];
    if (err_of()) return 2'b01;
    return {(!il || a[0] == !eo) && b >= st && b < st + cap_of(), 1'b0};
  endfunction
  // ==========
  // monitor
  always @(posedge sys_clk) begin
    if (pend) chk("mem", mq.pop_front(), {mem_hit, mem_refuse});
    if (avs_read && !avs_waitrequest) chk("rdata", rq.pop_front(), avs_readdata);
    pend = mem_req_valid && !rst;
  end
  initial begin
    #(25 * 20000);
    mismatches++;
    end_sim();
  end
  // ==========
  // main
  initial begin
    seed = 32'h7DAA;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rq.push_back(32'h1);
    bus(0, CSD_OFS_CONTROL, 0);
    rq.push_back(32'h0);
    bus(0, 4'h2, 0);
    for (int k = 0; k < 14; k++) begin
      cfg = $random(seed);
      st <= cfg[8:0];
      il <= cfg[9];
      eo <= cfg[10];
      pres <= cfg[14:11];
      big <= cfg[18:15];
      repeat (3) @(posedge sys_clk);
      chk("indicator", {31'h0, err_of()}, {31'h0, config_error_indicator});
      rq.push_back({8'h0, pres, big, 4'(cap_of()), err_of(), eo, il, st});
      bus(0, CSD_OFS_CONFIG, 0);
      // an error that newly appears leaves its rising-edge event pending
      rq.push_back({31'h0, err_of() && !pe});
      pe = err_of();
      bus(0, CSD_OFS_EVENT, 0);
      bus(1, CSD_OFS_MASK, {29'h0, cfg[21:19]});
      cfg[2:0] = 3'h0;
      for (int n = 0; n < 7; n++) begin
        r = $random(seed);
        r[23:14] = 10'(st) + 10'(n) - 10'h1;
        if (il) r[23:15] = r[22:14];
        mq.push_back(exp_of(r[23:0]));
        cfg[2] = cfg[2] | mq[$][1];
        u_csd_cache_model.send(r[23:0]);
      end
      u_csd_cache_model.idle();
      repeat (2) @(posedge sys_clk);
      cfg[1:0] = {err_of(), 1'b0};
      chk("irq", {31'h0, |(cfg[2:0] & cfg[21:19])}, {31'h0, irq});
      rq.push_back({29'h0, cfg[2:1], 1'b0});
      bus(0, CSD_OFS_EVENT, 0);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    end_sim();
  end
endmodule
bind csd_strap_decode csd_props u_csd_props (.sys_clk(sys_clk), .rst(rst),
  .start_addr_strap(start_addr_strap), .interleave_enable_strap(interleave_enable_strap),
  .even_odd_select_strap(even_odd_select_strap), .mem_req_valid(mem_req_valid),
  .mem_req_dw_addr(mem_req_dw_addr), .mem_hit(mem_hit), .mem_refuse(mem_refuse),
  .config_error_indicator(config_error_indicator), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq));
